// ### shared/smcw_pkg.sv
// Purpose: Shared constants and types for the serial memory command front end.
// Assumes: Byte wide memory of 32K locations behind a 15-bit address.
// Notes:   Op-codes and status layout are fixed by the serial protocol.
`default_nettype none

package smcw_pkg;

  localparam int         ADDR_W          = 15;
  localparam logic [7:0] OP_SET_WEL      = 8'h06;
  localparam logic [7:0] OP_CLR_WEL      = 8'h04;
  localparam logic [7:0] OP_STAT_RD      = 8'h05;
  localparam logic [7:0] OP_STAT_WR      = 8'h01;
  localparam logic [7:0] OP_MEM_RD       = 8'h03;
  localparam logic [7:0] OP_MEM_WR       = 8'h02;
  localparam int         ST_PEN          = 7;
  localparam int         ST_BPHI         = 3;
  localparam int         ST_BPLO         = 2;
  localparam int         ST_WEL          = 1;
  localparam logic [7:0] ST_RESET        = 8'h00;
  localparam logic [1:0] BP_NONE         = 2'h0;
  localparam logic [1:0] BP_QUARTER      = 2'h1;
  localparam logic [1:0] BP_HALF         = 2'h2;
  localparam logic [14:0] PROT_QTR_BASE  = 15'h6000;
  localparam logic [14:0] PROT_HALF_BASE = 15'h4000;
  localparam logic [2:0] BIT_LAST        = 3'h7;

  typedef enum logic [2:0]
  {
    PH_OPC    = 3'b000,
    PH_ADDRHI = 3'b001,
    PH_ADDRLO = 3'b010,
    PH_WRDATA = 3'b011,
    PH_RDDATA = 3'b100,
    PH_STIN   = 3'b101,
    PH_STOUT  = 3'b110,
    PH_IGN    = 3'b111
  } smcw_phase_t;

  typedef enum logic [2:0]
  {
    EV_SET_WEL = 3'b000,
    EV_CLR_WEL = 3'b001,
    EV_STAT_WR = 3'b010,
    EV_MEM_WR  = 3'b011,
    EV_MEM_RD  = 3'b100
  } smcw_event_t;

  function automatic logic smcw_prot_hit(input logic [1:0] bp, input logic [14:0] addr);
    logic hit;
    hit = 1'b1;
    case (bp)
      BP_NONE:    hit = 1'b0;
      BP_QUARTER: hit = (addr >= PROT_QTR_BASE);
      BP_HALF:    hit = (addr >= PROT_HALF_BASE);
      default:    hit = 1'b1;
    endcase
    return hit;
  endfunction : smcw_prot_hit

endpackage : smcw_pkg

`default_nettype wire

// ### design/smcw_spi_mem.sv
// Purpose: Serial slave command front end with write latch and layered write protection.
// Assumes: Serial clock is its own domain; memory array sits on clk with one-cycle read latency.
// Notes:   Read data crosses on timing margin: a fetch finishes within half a serial clock period.
//
// What this block does
// - Modes 0 and 3, chosen afresh per frame.
// - Ignore clock and data while deselected.
// - Sample on rising edge, launch on falling.
// - Eight-bit units, most significant bit first.
// - First byte of frame is the op-code.
// - One op-code per chip-select frame.
// - Op-codes set and clear the write latch.
// - Status read returns exactly one status byte.
// - Status write loads writable bits if permitted.
// - Memory read and write op-codes take address.
// - Latch starts cleared; master sets before writes.
// - Frame end after any write clears latch.
// - Latch flag in status is read-only.
// - Status layout fixed; unused bits read zero.
// - Block-protect bits survive power cycles.
// - Block-protect code selects the protected range.
// - Protect pin gates status writes when enabled.
// - Memory writes need latch and unprotected address.
// - Two address bytes, upper bit ignored.
// - Address advances per byte and wraps.
// - Output driven only while returning read data.
// - Hold low pauses, hold high resumes.
`timescale 1ns/1ps
`default_nettype none

module smcw_spi_mem
  import smcw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        sck,
  input  wire logic        csN,
  input  wire logic        si,
  input  wire logic        holdN,
  input  wire logic        wpN,
  output logic             soOut,
  output logic             soOe,
  output logic             memWe,
  output logic             memRe,
  output logic [14:0]      memAddr,
  output logic [7:0]       memWrData,
  input  wire logic [7:0]  memRdData,
  input  wire logic [1:0]  nvBlockProtectIn,
  input  wire logic        nvProtectEnableIn,
  output logic [1:0]       nvBlockProtect,
  output logic             nvProtectEnable
);

  // Link domain state.
  logic [2:0]   bitCnt;
  logic [6:0]   rxShift;
  logic [7:0]   rxByte;
  logic         byteDone;
  smcw_phase_t  phase;
  logic         isRd;
  logic [14:0]  linkAddr;
  logic         loadReq;
  logic [7:0]   txShift;
  logic [7:0]   txSrc;
  logic         soDrive;
  logic         evFire;
  smcw_event_t  evKind;
  logic [14:0]  evAddr;
  logic [7:0]   evData;
  logic         reqToggle;
  smcw_event_t  reqKind;
  logic [14:0]  reqAddr;
  logic [7:0]   reqData;

  // Core domain state.
  logic [1:0]   csSync;
  logic [1:0]   wpSync;
  logic [2:0]   reqSync;
  logic         csPrev;
  logic         csHigh;
  logic         frameStart;
  logic         evValid;
  logic         wpLatched;
  logic         nvLoaded;
  logic         write_enable_latch;
  logic         pin_protect_enable;
  logic [1:0]   bp;
  logic         frameWrote;
  logic         rdValid;
  logic [7:0]   rdHold;
  logic [7:0]   statusByte;
  logic [7:0]   next_status;

  assign rxByte   = {rxShift, si};
  assign byteDone = holdN && (bitCnt == BIT_LAST);

  // Chip select high holds the whole frame in reset, so a new frame always restarts at the op-code.
  always_ff @(posedge sck or posedge rst or posedge csN)
  begin
    if (rst || csN)
    begin
      bitCnt  <= 3'h0;
      rxShift <= 7'h00;
    end
    else if (holdN)
    begin
      bitCnt  <= 3'(bitCnt + 3'h1);
      rxShift <= {rxShift[5:0], si};
    end
  end

  always_ff @(posedge sck or posedge rst or posedge csN)
  begin
    if (rst || csN)
    begin
      phase    <= PH_OPC;
      isRd     <= 1'b0;
      linkAddr <= 15'h0000;
      loadReq  <= 1'b0;
    end
    else
    begin
      loadReq <= 1'b0;
      if (byteDone)
      begin
        case (phase)
          PH_OPC:
          begin
            case (rxByte)
              OP_STAT_RD:
              begin
                phase   <= PH_STOUT;
                loadReq <= 1'b1;
              end
              OP_STAT_WR: phase <= PH_STIN;
              OP_MEM_RD, OP_MEM_WR:
              begin
                phase <= PH_ADDRHI;
                isRd  <= (rxByte == OP_MEM_RD);
              end
              default: phase <= PH_IGN;
            endcase
          end
          PH_ADDRHI:
          begin
            linkAddr[14:8] <= rxByte[6:0];
            phase          <= PH_ADDRLO;
          end
          PH_ADDRLO:
          begin
            linkAddr[7:0] <= rxByte;
            phase         <= isRd ? PH_RDDATA : PH_WRDATA;
            loadReq       <= isRd;
          end
          PH_RDDATA:
          begin
            linkAddr <= 15'(linkAddr + 15'h0001);
            loadReq  <= 1'b1;
          end
          PH_WRDATA: linkAddr <= 15'(linkAddr + 15'h0001);
          PH_STIN:   phase <= PH_IGN;
          PH_STOUT:  phase <= PH_IGN;
          default:   phase <= PH_IGN;
        endcase
      end
    end
  end

  // Requests toward the core domain; payload stays put until the next request a byte later.
  always_comb
  begin
    evFire = 1'b0;
    evKind = EV_MEM_RD;
    evAddr = linkAddr;
    evData = rxByte;
    if (byteDone)
    begin
      case (phase)
        PH_OPC:
        begin
          evFire = (rxByte == OP_SET_WEL) || (rxByte == OP_CLR_WEL);
          evKind = (rxByte == OP_SET_WEL) ? EV_SET_WEL : EV_CLR_WEL;
        end
        PH_STIN:
        begin
          evFire = 1'b1;
          evKind = EV_STAT_WR;
        end
        PH_ADDRLO:
        begin
          evFire = isRd;
          evAddr = {linkAddr[14:8], rxByte};
        end
        PH_RDDATA:
        begin
          evFire = 1'b1;
          evAddr = 15'(linkAddr + 15'h0001);
        end
        PH_WRDATA:
        begin
          evFire = 1'b1;
          evKind = EV_MEM_WR;
        end
        default: evFire = 1'b0;
      endcase
    end
  end

  // Not reset by chip select: a reset here would fake a toggle toward the core.
  always_ff @(posedge sck or posedge rst)
  begin
    if (rst)
    begin
      reqToggle <= 1'b0;
      reqKind   <= EV_MEM_RD;
      reqAddr   <= 15'h0000;
      reqData   <= 8'h00;
    end
    else if (!csN && evFire)
    begin
      reqToggle <= ~reqToggle;
      reqKind   <= evKind;
      reqAddr   <= evAddr;
      reqData   <= evData;
    end
  end

  assign txSrc = (phase == PH_STOUT) ? statusByte : rdHold;

  always_ff @(negedge sck or posedge rst or posedge csN)
  begin
    if (rst || csN)
    begin
      txShift <= 8'h00;
      soOut   <= 1'b0;
      soDrive <= 1'b0;
    end
    else if (holdN)
    begin
      if (loadReq)
      begin
        txShift <= txSrc;
        soOut   <= txSrc[7];
        soDrive <= 1'b1;
      end
      else
      begin
        txShift <= {txShift[6:0], 1'b0};
        soOut   <= txShift[6];
        soDrive <= (phase == PH_RDDATA) || (phase == PH_STOUT);
      end
    end
  end

  assign soOe = soDrive && holdN;

  // Core domain: synchronisers; the first stages never feed logic, and the request edge uses the last two stages.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      csSync  <= 2'h3;
      wpSync  <= 2'h3;
      reqSync <= 3'h0;
      csPrev  <= 1'b1;
    end
    else if (ce)
    begin
      csSync  <= {csSync[0], csN};
      wpSync  <= {wpSync[0], wpN};
      reqSync <= {reqSync[1:0], reqToggle};
      csPrev  <= csSync[1];
    end
  end

  assign csHigh     = csSync[1];
  assign frameStart = csPrev && !csSync[1];
  assign evValid    = reqSync[2] ^ reqSync[1];

  // The pin is taken once per frame so a change mid-frame waits for the next select.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wpLatched <= 1'b1;
    else if (ce && frameStart)
      wpLatched <= wpSync[1];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      write_enable_latch <= 1'b0;
    else if (ce)
    begin
      if (evValid && reqKind == EV_SET_WEL)
        write_enable_latch <= 1'b1;
      else if ((evValid && reqKind == EV_CLR_WEL) || (csHigh && frameWrote))
        write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      frameWrote <= 1'b0;
    else if (ce)
    begin
      if (evValid && (reqKind == EV_STAT_WR || reqKind == EV_MEM_WR))
        frameWrote <= 1'b1;
      else if (csHigh)
        frameWrote <= 1'b0;
    end
  end

  // Protection bits come back from backing storage in the first enabled cycle after reset.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nvLoaded <= 1'b0;
      pin_protect_enable     <= 1'b0;
      bp       <= BP_NONE;
    end
    else if (ce)
    begin
      if (!nvLoaded)
      begin
        nvLoaded <= 1'b1;
        pin_protect_enable     <= nvProtectEnableIn;
        bp       <= nvBlockProtectIn;
      end
      else if (evValid && reqKind == EV_STAT_WR && write_enable_latch && !(pin_protect_enable && !wpLatched))
      begin
        pin_protect_enable <= reqData[ST_PEN];
        bp   <= reqData[ST_BPHI:ST_BPLO];
      end
    end
  end

  assign nvBlockProtect  = bp;
  assign nvProtectEnable = pin_protect_enable;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      memWe     <= 1'b0;
      memRe     <= 1'b0;
      memAddr   <= 15'h0000;
      memWrData <= 8'h00;
      rdValid   <= 1'b0;
      rdHold    <= 8'h00;
    end
    else if (ce)
    begin
      memWe   <= evValid && reqKind == EV_MEM_WR && write_enable_latch && !smcw_prot_hit(bp, reqAddr);
      memRe   <= evValid && reqKind == EV_MEM_RD;
      rdValid <= memRe;
      if (evValid)
      begin
        memAddr   <= reqAddr;
        memWrData <= reqData;
      end
      if (rdValid)
        rdHold <= memRdData;
    end
  end

  always_comb
  begin
    next_status         = ST_RESET;
    next_status[ST_PEN] = pin_protect_enable;
    next_status[ST_BPHI] = bp[1];
    next_status[ST_BPLO] = bp[0];
    next_status[ST_WEL] = write_enable_latch;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      statusByte <= ST_RESET;
    else if (ce)
      statusByte <= next_status;
  end

  we_needs_wel_a: assert property (@(posedge clk) disable iff (rst) memWe |-> $past(write_enable_latch))
    else $error("Memory write issued with the latch clear.");
  we_range_a: assert property (@(posedge clk) disable iff (rst) memWe |-> !smcw_prot_hit($past(bp), memAddr))
    else $error("Memory write hit a protected address.");
  wel_set_a: assert property (@(posedge clk) disable iff (rst)
    (ce && evValid && reqKind == EV_SET_WEL) |=> write_enable_latch)
    else $error("Latch did not set.");
  wel_clr_a: assert property (@(posedge clk) disable iff (rst)
    (ce && evValid && reqKind == EV_CLR_WEL) |=> !write_enable_latch)
    else $error("Latch did not clear.");
  wel_end_a: assert property (@(posedge clk) disable iff (rst)
    (ce && csHigh && frameWrote && !(evValid && reqKind == EV_SET_WEL)) |=> !write_enable_latch)
    else $error("Latch survived the end of a write frame.");
  stat_lock_a: assert property (@(posedge clk) disable iff (rst)
    (ce && nvLoaded && evValid && reqKind == EV_STAT_WR && pin_protect_enable && !wpLatched)
    |=> $stable(bp) && $stable(pin_protect_enable))
    else $error("Status changed while pin protection was active.");
  stat_fixed_a: assert property (@(posedge clk) disable iff (rst)
    statusByte[6:4] == 3'h0 && !statusByte[0])
    else $error("Fixed status bits are not zero.");
  bit_step_a: assert property (@(posedge sck) disable iff (rst || csN)
    holdN |=> bitCnt == 3'($past(bitCnt) + 3'h1))
    else $error("Bit counter did not advance.");
  hold_pause_a: assert property (@(posedge sck) disable iff (rst || csN)
    !holdN |=> $stable(bitCnt))
    else $error("Bit counter moved during hold.");
  so_phase_a: assert property (@(posedge sck) disable iff (rst || csN)
    soDrive |-> (phase == PH_RDDATA || phase == PH_STOUT))
    else $error("Output driven outside a read phase.");

endmodule : smcw_spi_mem

`default_nettype wire

// ### tb/smcw_host.sv
// Purpose: Serial bus master model for the memory front end.
// Assumes: Modes 0 and 3 only, with a 160 ns serial period.
// Notes:   Between frames the clock moves only to the next frame's idle level, and the data line is turned over 40 ns before deselect, while still selected.
`timescale 1ns/1ps
`default_nettype none
module smcw_host
(
  output logic      sck,
  output logic      csN,
  output logic      si,
  output logic      holdN,
  input  wire logic soOut,
  input  wire logic soOe
);
  logic mode3;
  initial
  begin
    sck   = 1'b0;
    csN   = 1'b1;
    si    = 1'b0;
    holdN = 1'b1;
    mode3 = 1'b0;
  end
  // Hold is taken and dropped with the clock low; the clocks given inside it must change nothing.
  task automatic pause(input int n);
    sck = 1'b0;
    #40;
    holdN = 1'b0;
    repeat (n)
    begin
      #40;
      sck = 1'b1;
      #40;
      sck = 1'b0;
    end
    #40;
    holdN = 1'b1;
    #40;
  endtask : pause
  task automatic open_frame(input logic m3);
    mode3 = m3;
    sck   = m3;
    #40;
    csN = 1'b0;
    #40;
  endtask : open_frame
  // A mode 3 frame lowers the clock at the first bit, so a rising edge takes it.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic [7:0] oe);
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      si  = tx[i];
      #80;
      sck   = 1'b1;
      rx[i] = soOut;
      oe[i] = soOe;
      #80;
    end
  endtask : xfer
  task automatic close_frame();
    if (!mode3)
      sck = 1'b0;
    si = ~si;
    #40;
    csN = 1'b1;
    #200;
  endtask : close_frame
endmodule : smcw_host
`default_nettype wire

// ### tb/test_smcw_spi_mem.sv
// Purpose: Self-checking bench for the serial memory front end.
// Assumes: Memory array and backing store are modelled here.
// Notes:   Expected memory contents are tracked in a shadow copy.
`timescale 1ns/1ps
`default_nettype none
module test_smcw_spi_mem
  import smcw_pkg::*;
;
  logic        clk, rst, wpN, sck, csN, si, soOut, soOe, memWe, memRe, nvPenIn, nvPen, ce, holdN;
  logic [14:0] memAddr;
  logic [7:0]  memWrData, rdq, rx, oe, st;
  logic [1:0]  nvBpIn, nvBp;
  logic [7:0]  mem [0:32767];
  logic [7:0]  shadow [0:32767];
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;
  smcw_spi_mem dut_u
  (
    .clk(clk), .rst(rst), .ce(ce), .sck(sck), .csN(csN), .si(si), .holdN(holdN), .wpN(wpN),
    .soOut(soOut), .soOe(soOe), .memWe(memWe), .memRe(memRe), .memAddr(memAddr), .memWrData(memWrData),
    .memRdData(rdq), .nvBlockProtectIn(nvBpIn), .nvProtectEnableIn(nvPenIn), .nvBlockProtect(nvBp),
    .nvProtectEnable(nvPen)
  );
  smcw_host host_u (.sck(sck), .csN(csN), .si(si), .holdN(holdN), .soOut(soOut), .soOe(soOe));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (memWe)
      mem[memAddr] <= memWrData;
    if (memRe)
      rdq <= mem[memAddr];
  end
  // The scenarios need about 56,000 cycles; the ceiling leaves room for slack but stops a hang.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  function automatic logic hit(input logic [1:0] bp, input logic [14:0] a);
    return bp == 2'h3 || (bp == 2'h2 && a >= 15'h4000) || (bp == 2'h1 && a >= 15'h6000);
  endfunction : hit
  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (12) @(negedge clk);
  endtask : do_reset
  task automatic cmd(input logic m3, input logic [7:0] op);
    host_u.open_frame(m3);
    host_u.xfer(op, rx, oe);
    host_u.close_frame();
  endtask : cmd
  task automatic stat_chk(input logic [7:0] exp);
    host_u.open_frame(1'b0);
    host_u.xfer(OP_STAT_RD, rx, oe);
    host_u.xfer(8'h00, st, oe);
    chk(oe, 8'hFF);
    host_u.xfer(8'h00, rx, oe);
    chk(oe, 8'h00);
    host_u.close_frame();
    chk(st, exp);
  endtask : stat_chk
  task automatic stat_wr(input logic [7:0] v);
    host_u.open_frame(1'b1);
    host_u.xfer(OP_STAT_WR, rx, oe);
    host_u.xfer(v, rx, oe);
    host_u.close_frame();
  endtask : stat_wr
  task automatic mem_wr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1,
                        input logic write_enable_latch, input logic [1:0] bp);
    logic [14:0] a1;
    a1 = a[14:0] + 15'h0001;
    if (write_enable_latch)
      cmd(1'b0, OP_SET_WEL);
    host_u.open_frame(1'b1);
    host_u.xfer(OP_MEM_WR, rx, oe);
    host_u.xfer(a[15:8], rx, oe);
    host_u.xfer(a[7:0], rx, oe);
    host_u.xfer(d0, rx, oe);
    host_u.xfer(d1, rx, oe);
    chk(oe, 8'h00);
    host_u.close_frame();
    if (write_enable_latch && !hit(bp, a[14:0]))
      shadow[a[14:0]] = d0;
    if (write_enable_latch && !hit(bp, a1))
      shadow[a1] = d1;
    chk(mem[a[14:0]], shadow[a[14:0]]);
    chk(mem[a1], shadow[a1]);
  endtask : mem_wr
  task automatic t_status();
    stat_chk(8'h00);
    cmd(1'b1, OP_SET_WEL);
    stat_chk(8'h02);
    cmd(1'b0, OP_CLR_WEL);
    stat_chk(8'h00);
    stat_wr(8'hFF);
    stat_chk(8'h00);
    cmd(1'b0, OP_SET_WEL);
    stat_wr(8'hFF);
    stat_chk(8'h8C);
    chk({6'h00, nvBp}, 8'h03);
    chk({7'h00, nvPen}, 8'h01);
    @(negedge clk);
    wpN = 1'b0;
    cmd(1'b0, OP_SET_WEL);
    stat_wr(8'h00);
    stat_chk(8'h8C);
    nvBpIn = nvBp;
    nvPenIn = nvPen;
    do_reset();
    stat_chk(8'h8C);
    @(negedge clk);
    wpN = 1'b1;
    cmd(1'b0, OP_SET_WEL);
    stat_wr(8'h04);
    stat_chk(8'h04);
    @(negedge clk);
    wpN = 1'b0;
    cmd(1'b0, OP_SET_WEL);
    stat_wr(8'h08);
    stat_chk(8'h08);
    @(negedge clk);
    wpN = 1'b1;
  endtask : t_status
  task automatic t_stray();
    host_u.open_frame(1'b0);
    host_u.xfer(8'hA5, rx, oe);
    host_u.xfer(OP_STAT_RD, rx, oe);
    host_u.xfer(8'h00, rx, oe);
    chk(oe, 8'h00);
    host_u.close_frame();
    host_u.open_frame(1'b0);
    host_u.xfer(OP_SET_WEL, rx, oe);
    host_u.xfer(OP_CLR_WEL, rx, oe);
    host_u.close_frame();
    stat_chk(8'h0A);
  endtask : t_stray
  task automatic t_protect();
    for (int b = 0; b < 4; b++)
    begin
      cmd(1'b0, OP_SET_WEL);
      stat_wr({4'h0, b[1:0], 2'h0});
      mem_wr(16'hBFFF, 8'h10 | 8'(b), 8'h20 | 8'(b), 1'b1, b[1:0]);
      mem_wr(16'h5FFF, 8'h30 | 8'(b), 8'h40 | 8'(b), 1'b1, b[1:0]);
      mem_wr(16'h0100, 8'h50, 8'h60, 1'b0, b[1:0]);
    end
    stat_chk(8'h0C);
  endtask : t_protect
  task automatic t_hold();
    host_u.open_frame(1'b0);
    host_u.xfer(OP_STAT_RD, rx, oe);
    fork
      host_u.pause(3);
      begin
        #100;
        chk({7'h00, soOe}, 8'h00);
      end
    join
    host_u.xfer(8'h00, st, oe);
    chk(oe, 8'hFF);
    host_u.close_frame();
    chk(st, 8'h0C);
  endtask : t_hold
  task automatic t_freeze();
    @(negedge clk);
    ce = 1'b0;
    cmd(1'b0, OP_SET_WEL);
    stat_chk(8'h0C);
    @(negedge clk);
    ce = 1'b1;
    repeat (8) @(negedge clk);
    stat_chk(8'h0E);
  endtask : t_freeze
  task automatic t_wrap();
    logic [14:0] ra;
    ra = 15'h7FFE;
    cmd(1'b0, OP_SET_WEL);
    stat_wr(8'h00);
    mem_wr(16'hFFFF, 8'h5A, 8'hA5, 1'b1, 2'h0);
    host_u.open_frame(1'b1);
    host_u.xfer(OP_MEM_RD, rx, oe);
    host_u.xfer(8'hFF, rx, oe);
    host_u.xfer(8'hFE, rx, oe);
    for (int i = 0; i < 3; i++)
    begin
      host_u.xfer(8'h00, rx, oe);
      chk(rx, shadow[ra]);
      chk(oe, 8'hFF);
      ra++;
    end
    host_u.close_frame();
  endtask : t_wrap
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    wpN = 1'b1;
    nvBpIn = 2'h0;
    nvPenIn = 1'b0;
    for (int a = 0; a < 32768; a++)
    begin
      mem[a] = 8'(a * 3);
      shadow[a] = 8'(a * 3);
    end
    do_reset();
    #1.3;
    chk({7'h00, soOe}, 8'h00);
    t_status();
    t_stray();
    t_protect();
    t_hold();
    t_freeze();
    t_wrap();
    close_out();
  end
endmodule : test_smcw_spi_mem
`default_nettype wire
